// >>> hdl/exc_seq_consts.vh
/*
  Constants for the exception and interrupt sequencer: stack frame size,
  vector selector codes, vector table top address and reset values.
  Assumes an 8-bit core with a 16-bit address bus and a descending stack.
*/
// What this block does
// - Handles maskable requests, software trap, reset and break as flow changes.
// - Software trap starts interrupt processing even while the mask flag is set.
// - Requests are latched; arbitration happens when interrupt processing begins.
// - Arbitration yields a fixed vector selector held stable during processing.
// - Latched winner stays until serviced or the mask flag is cleared while idle.
// - Entry pushes core registers onto the stack before the vector fetch.
// - Entry sets the mask flag so maskable requests are blocked.
// - Return instruction pops saved registers so the program resumes unchanged.
// - Requests checked only at instruction end, with mask clear and source enabled.
// - Highest priority first; pending requests taken at the end of the next program instruction.
// - Index high byte not pushed; trap and break stack PC, maskable requests stack PC minus one.
`ifndef EXC_SEQ_CONSTS_VH
`define EXC_SEQ_CONSTS_VH

`define NUM_SOURCES       8
`define SEL_WIDTH         4
`define SEL_RESET         4'h0
`define SEL_TRAP          4'h1
`define SEL_HW_BASE       4'h2
`define SEL_BREAK         4'hf
`define VECTOR_TOP        16'hfffe
`define MASK_BIT          3
`define CCR_RESET         8'hff
`define SP_RESET          16'h00ff
`define FRAME_BYTES       16'h0005

`endif

// >>> hdl/stack_frame_mem.v
/*
  Small register-read memory holding the five stacked bytes of the frame.
  Assumes one write or one read per cycle; read data arrive one cycle late.
*/
`timescale 1ns/1ps
module stack_frame_mem #(
  parameter DEPTH = 256
) (
  input  wire       ref_clk_in,
  input  wire       wr_en_in,
  input  wire [7:0] addr_in,
  input  wire [7:0] wdata_in,
  output reg  [7:0] rdata_out
);
  reg [7:0] mem [0:DEPTH-1];

  // Synchronous write, registered read
  always @(posedge ref_clk_in) begin
    if (wr_en_in) begin
      mem[addr_in] <= wdata_in;
    end
    rdata_out <= mem[addr_in];
  end
endmodule

// >>> hdl/exception_interrupt_sequencer.v
/*
  Exception sequencer: latches requests, arbitrates at entry, holds the
  vector selector, runs the stacking and return sequences on the stack memory.
  Assumes the core pulses instruction end, trap and return, and supplies PC,
  A and X to be saved; the stacked CCR is the sequencer's own; restored values come back on the *_out ports.
*/
`timescale 1ns/1ps
`include "exc_seq_consts.vh"
module exception_interrupt_sequencer #(
  parameter N = `NUM_SOURCES
) (
  input  wire                   ref_clk_in,
  input  wire                   rst_in,
  input  wire [N-1:0]           irq_in,
  input  wire [N-1:0]           irq_enable_in,
  input  wire                   instr_done_in,
  input  wire                   software_trap_instruction_in,
  input  wire                   return_from_interrupt_in,
  input  wire                   break_in,
  input  wire                   mask_clear_in,
  input  wire [15:0]            pc_in,
  input  wire [7:0]             acc_in,
  input  wire [7:0]             index_lo_in,
  output reg  [`SEL_WIDTH-1:0]  vector_sel_out,
  output reg  [15:0]            internal_address_bus_out,
  output reg                    write_out,
  output reg                    busy_out,
  output reg                    mask_flag_out,
  output reg  [7:0]             condition_code_register_out,
  output reg  [15:0]            pc_out,
  output reg  [7:0]             acc_out,
  output reg  [7:0]             index_lo_out,
  output reg                    restore_valid_out
);
  // One-hot states
  localparam S_IDLE  = 4'b0001;
  localparam S_ENTRY = 4'b0010;
  localparam S_RET   = 4'b0100;
  localparam S_DONE  = 4'b1000;

  reg [3:0]         state;
  reg [2:0]         step;
  reg [N-1:0]       pend;
  reg [N-1:0]       sync1;
  reg [N-1:0]       sync2;
  reg               winner_valid;
  reg               trap_pend;
  reg [15:0]        sp;
  reg [15:0]        ret_addr;
  reg [7:0]         mem_addr;
  reg [7:0]         mem_wdata;
  reg               mem_we;
  wire [7:0]        mem_rdata;
  wire [N-1:0]      eligible;

  // Lowest index wins; used at entry only, the pending check is |eligible
  function [`SEL_WIDTH-1:0] pick;
    input [N-1:0] req;
    integer k;
    begin
      pick = `SEL_HW_BASE;
      for (k = N - 1; k >= 0; k = k - 1) begin
        if (req[k]) begin
          pick = `SEL_HW_BASE + k[`SEL_WIDTH-1:0];
        end
      end
    end
  endfunction

  assign eligible = pend & irq_enable_in;

  stack_frame_mem #(
    .DEPTH (256)
  ) u_mem (
    .ref_clk_in (ref_clk_in),
    .wr_en_in   (mem_we),
    .addr_in    (mem_addr),
    .wdata_in   (mem_wdata),
    .rdata_out  (mem_rdata)
  );

  // Pins cross two flops before any logic sees them
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1 <= {N{1'b0}};
      sync2 <= {N{1'b0}};
    end else begin
      sync1 <= irq_in;
      sync2 <= sync1;
    end
  end

  // Main sequencer
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state                       <= S_IDLE;
      step                        <= 3'h0;
      pend                        <= {N{1'b0}};
      winner_valid                <= 1'b0;
      trap_pend                   <= 1'b0;
      sp                          <= `SP_RESET;
      ret_addr                    <= 16'h0000;
      mem_addr                    <= 8'h00;
      mem_wdata                   <= 8'h00;
      mem_we                      <= 1'b0;
      vector_sel_out              <= `SEL_RESET;
      internal_address_bus_out    <= `VECTOR_TOP;
      write_out                   <= 1'b0;
      busy_out                    <= 1'b0;
      mask_flag_out               <= 1'b1;
      condition_code_register_out <= `CCR_RESET;
      pc_out                      <= 16'h0000;
      acc_out                     <= 8'h00;
      index_lo_out                <= 8'h00;
      restore_valid_out           <= 1'b0;
    end else begin
      mem_we            <= 1'b0;
      write_out         <= 1'b0;
      restore_valid_out <= 1'b0;
      pend <= pend | sync2;
      if (mask_clear_in) begin
        mask_flag_out <= 1'b0;
        condition_code_register_out[`MASK_BIT] <= 1'b0;
        if (state == S_IDLE) begin
          winner_valid <= 1'b0;
        end
      end
      if (software_trap_instruction_in) begin
        trap_pend <= 1'b1;
      end
      case (state)
        S_IDLE: begin
          busy_out <= 1'b0;
          // break handled like an unmaskable entry
          if (break_in && instr_done_in) begin
            vector_sel_out <= `SEL_BREAK;
            ret_addr       <= pc_in;
            state          <= S_ENTRY;
            step           <= 3'h0;
            busy_out       <= 1'b1;
          end else if ((trap_pend || software_trap_instruction_in) && instr_done_in) begin
            trap_pend      <= 1'b0;
            vector_sel_out <= `SEL_TRAP;
            ret_addr       <= pc_in;
            state          <= S_ENTRY;
            step           <= 3'h0;
            busy_out       <= 1'b1;
          end else if (instr_done_in && !mask_flag_out && (|eligible)) begin
            if (!winner_valid) begin
              vector_sel_out <= pick(eligible);
              winner_valid   <= 1'b1;
            end
            ret_addr <= pc_in - 16'h0001;
            state    <= S_ENTRY;
            step     <= 3'h0;
            busy_out <= 1'b1;
          end else if (return_from_interrupt_in) begin
            state    <= S_RET;
            step     <= 3'h0;
            busy_out <= 1'b1;
          end
        end
        S_ENTRY: begin
          step <= step + 3'h1;
          case (step)
            3'h0: begin
              internal_address_bus_out <= sp;
              mask_flag_out <= 1'b1;
            end
            3'h1, 3'h2, 3'h3, 3'h4, 3'h5: begin
              internal_address_bus_out <= sp;
              mem_addr  <= sp[7:0];
              mem_we    <= 1'b1;
              write_out <= 1'b1;
              sp        <= sp - 16'h0001;
              case (step)
                3'h1: mem_wdata <= ret_addr[7:0];
                3'h2: mem_wdata <= ret_addr[15:8];
                3'h3: mem_wdata <= index_lo_in;
                3'h4: mem_wdata <= acc_in;
                default: mem_wdata <= condition_code_register_out;
              endcase
            end
            3'h6: begin
              internal_address_bus_out <= `VECTOR_TOP - {11'h000, vector_sel_out, 1'b0};
              condition_code_register_out[`MASK_BIT] <= 1'b1;
            end
            default: begin
              internal_address_bus_out <= `VECTOR_TOP - {11'h000, vector_sel_out, 1'b0}
                                          + 16'h0001;
              state <= S_DONE;
            end
          endcase
        end
        S_RET: begin
          step <= step + 3'h1;
          if (step < 3'h5) begin
            sp       <= sp + 16'h0001;
            mem_addr <= sp[7:0] + 8'h01;
            internal_address_bus_out <= sp + 16'h0001;
          end
          // Read data lag the address by one cycle
          case (step)
            3'h2: condition_code_register_out <= mem_rdata;
            3'h3: acc_out <= mem_rdata;
            3'h4: index_lo_out <= mem_rdata;
            3'h5: pc_out[15:8] <= mem_rdata;
            3'h6: begin
              pc_out[7:0]       <= mem_rdata;
              mask_flag_out     <= condition_code_register_out[`MASK_BIT];
              restore_valid_out <= 1'b1;
              winner_valid      <= 1'b0;
              // others stay pending until the next instruction end
              // A fresh request in the clearing cycle is kept: set beats clear
              pend  <= (pend & ~(winner_valid ?
                       ({{(N-1){1'b0}}, 1'b1} << (vector_sel_out - `SEL_HW_BASE))
                       : {N{1'b0}})) | sync2;
              state <= S_IDLE;
            end
            default: begin
            end
          endcase
        end
        S_DONE: begin
          busy_out <= 1'b0;
          state    <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// >>> tb/exc_seq_chk.sv
/*
  Port checker for the exception sequencer.
  Assumes a bind onto the sequencer, one clock and an async high reset.
*/
`timescale 1ns/1ps
`include "exc_seq_consts.vh"
module exc_seq_chk (
  input wire                  ref_clk_in,
  input wire                  rst_in,
  input wire                  instr_done_in,
  input wire                  software_trap_instruction_in,
  input wire                  return_from_interrupt_in,
  input wire                  break_in,
  input wire                  busy_out,
  input wire                  write_out,
  input wire                  mask_flag_out,
  input wire                  restore_valid_out,
  input wire [`SEL_WIDTH-1:0] vector_sel_out,
  input wire [15:0]           internal_address_bus_out
);
  reg  busy_d;
  reg  rti_d;
  wire idle_take   = !busy_out && instr_done_in;
  // Return also raises busy, so entry is told apart by the previous cycle
  wire entry_start = busy_out && !busy_d && !rti_d;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Delayed copies for edge detection
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_d <= 1'b0;
      rti_d  <= 1'b0;
    end else begin
      busy_d <= busy_out;
      rti_d  <= return_from_interrupt_in;
    end
  end
  trap_taken_a: assert property (idle_take && software_trap_instruction_in && !break_in
    |=> busy_out ##1 vector_sel_out == `SEL_TRAP) else $error("trap not taken");
  break_sel_a: assert property (idle_take && break_in
    |=> ##1 vector_sel_out == `SEL_BREAK) else $error("break selector wrong");
  mask_set_a: assert property (entry_start |=> mask_flag_out) else $error("mask not set");
  push_five_a: assert property (entry_start
    |-> !write_out ##2 write_out [*5] ##1 !write_out) else $error("push count wrong");
  vector_fetch_a: assert property (entry_start
    |-> ##7 internal_address_bus_out == 16'hfffe - {vector_sel_out, 1'b0}
    ##1 internal_address_bus_out == 16'hffff - {vector_sel_out, 1'b0}) else $error("vector addr");
  entry_len_a: assert property (entry_start
    |-> busy_out [*8] ##1 busy_out ##1 !busy_out) else $error("entry length wrong");
  sel_hold_a: assert property (busy_out && busy_d |-> $stable(vector_sel_out))
    else $error("selector moved");
  stack_down_a: assert property (write_out && $past(write_out)
    |-> internal_address_bus_out == $past(internal_address_bus_out) - 16'h1) else $error("stack");
  mask_block_a: assert property (idle_take && mask_flag_out && !software_trap_instruction_in
    && !break_in && !return_from_interrupt_in |=> !busy_out) else $error("masked request taken");
  no_done_a: assert property (!busy_out && !instr_done_in && !return_from_interrupt_in
    |=> !busy_out) else $error("entry without instruction end");
  restore_time_a: assert property (!busy_out && return_from_interrupt_in && !instr_done_in
    |-> ##8 restore_valid_out) else $error("restore late");
endmodule

// >>> tb/core_model.sv
/*
  Core model: ends instructions, issues trap and return pulses, supplies
  the values to stack. Assumes the sequencer samples on the rising edge.
*/
`timescale 1ns/1ps
module core_model (
  input  wire        ref_clk_in,
  input  wire        rst_in,
  input  wire        busy_in,
  input  wire        trap_req_in,
  input  wire        rti_req_in,
  output reg         instr_done_out,
  output reg         trap_out,
  output reg         rti_out,
  output reg  [15:0] pc_out,
  output wire [7:0]  acc_out,
  output wire [7:0]  index_lo_out
);
  reg rti_sent;
  // Derived from PC so every frame differs
  assign acc_out      = pc_out[7:0] ^ 8'h3c;
  assign index_lo_out = pc_out[7:0] + 8'h11;
  // One return per request; no instruction ends while it is pending
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      instr_done_out <= 1'h0;
      trap_out       <= 1'h0;
      rti_out        <= 1'h0;
      rti_sent       <= 1'h0;
      pc_out         <= 16'h8000;
    end else begin
      instr_done_out <= 1'h0;
      trap_out       <= 1'h0;
      rti_out        <= 1'h0;
      if (!rti_req_in)
        rti_sent <= 1'h0;
      if (!busy_in && !instr_done_out && !rti_out) begin
        if (rti_req_in && !rti_sent) begin
          rti_out  <= 1'h1;
          rti_sent <= 1'h1;
        end else if (!rti_req_in) begin
          instr_done_out <= 1'h1;
          trap_out       <= trap_req_in;
          pc_out         <= pc_out + 16'h1;
        end
      end
    end
  end
endmodule

// >>> tb/testbench.sv
/*
  Bench for the exception sequencer beside a core model.
  Assumes a 10 MHz clock, async high reset and the checker bound below.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench;
  typedef struct {logic clr, trap, brk; logic [7:0] irq, en; logic [3:0] sel;} row_t;
  reg         ref_clk_in = 1'h0;
  reg         rst_in = 1'h1;
  reg  [7:0]  irq_in = 8'h00;
  reg  [7:0]  irq_enable_in = 8'h00;
  reg         break_in = 1'h0;
  reg         mask_clear_in = 1'h0;
  reg         trap_req = 1'h0;
  reg         rti_req = 1'h0;
  reg         mb;
  reg  [15:0] epc;
  reg  [7:0]  ea, ex;
  wire        instr_done_in, software_trap_instruction_in, return_from_interrupt_in;
  wire        busy_out, mask_flag_out, write_out, restore_valid_out;
  wire [15:0] pc_in, internal_address_bus_out, pc_out;
  wire [7:0]  acc_in, index_lo_in, acc_out, index_lo_out, condition_code_register_out;
  wire [3:0]  vector_sel_out;
  integer     bad_count = 0, checks = 0, cycles = 0, i;
  // Clear, trap, break, requests, enables, expected selector
  row_t rows [7] = '{'{1'h0, 1'h1, 1'h0, 8'h00, 8'h00, 4'h1},
    '{1'h1, 1'h0, 1'h0, 8'h01, 8'hff, 4'h2}, '{1'h1, 1'h0, 1'h0, 8'h28, 8'hff, 4'h5},
    '{1'h0, 1'h0, 1'h0, 8'h00, 8'hff, 4'h7}, '{1'h0, 1'h0, 1'h1, 8'h00, 8'hff, 4'hf},
    '{1'h1, 1'h1, 1'h0, 8'h80, 8'hff, 4'h1}, '{1'h0, 1'h0, 1'h0, 8'h00, 8'hff, 4'h9}};
  core_model u_core_model (.ref_clk_in, .rst_in, .busy_in(busy_out), .trap_req_in(trap_req),
    .rti_req_in(rti_req), .instr_done_out(instr_done_in), .trap_out(software_trap_instruction_in),
    .rti_out(return_from_interrupt_in), .pc_out(pc_in), .acc_out(acc_in),
    .index_lo_out(index_lo_in));
  exception_interrupt_sequencer u_exception_interrupt_sequencer (.ref_clk_in, .rst_in, .irq_in,
    .irq_enable_in, .instr_done_in, .software_trap_instruction_in, .return_from_interrupt_in,
    .break_in, .mask_clear_in, .pc_in, .acc_in, .index_lo_in, .vector_sel_out,
    .internal_address_bus_out, .write_out, .busy_out, .mask_flag_out,
    .condition_code_register_out, .pc_out, .acc_out, .index_lo_out, .restore_valid_out);
  always #50 ref_clk_in = ~ref_clk_in;
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      close_out;
    end
  end
  // Bounded wait on busy or on the restore pulse, sampled at falling edges
  task wait_for(input bit use_rv, input logic lvl);
    integer n;
    for (n = 0; n < 40 && ((use_rv ? restore_valid_out : busy_out) !== lvl); n++)
      @(negedge ref_clk_in);
    `CHK(use_rv ? restore_valid_out : busy_out, lvl)
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    mb = 1'h1;
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'h0;
    for (i = 0; i < 7; i++) begin
      @(posedge ref_clk_in);
      mask_clear_in <= rows[i].clr;
      irq_enable_in <= rows[i].en;
      @(posedge ref_clk_in);
      mask_clear_in <= 1'h0;
      irq_in <= rows[i].irq;
      break_in <= rows[i].brk;
      trap_req <= rows[i].trap;
      if (rows[i].clr)
        mb = 1'h0;
      @(negedge ref_clk_in);
      wait_for(0, 1'h1);
      epc = pc_in - ((rows[i].sel == 4'h1) ? 16'h0 : 16'h1);
      ea = acc_in;
      ex = index_lo_in;
      @(posedge ref_clk_in);
      irq_in <= 8'h00;
      break_in <= 1'h0;
      trap_req <= 1'h0;
      @(negedge ref_clk_in);
      `CHK(vector_sel_out, rows[i].sel)
      `CHK(mask_flag_out, 1'h1)
      wait_for(0, 1'h0);
      @(posedge ref_clk_in);
      rti_req <= 1'h1;
      @(negedge ref_clk_in);
      wait_for(1, 1'h1);
      if (!rows[i].brk) `CHK(pc_out, epc)
      `CHK({acc_out, index_lo_out}, {ea, ex})
      @(posedge ref_clk_in);
      rti_req <= 1'h0;
      @(negedge ref_clk_in);
      wait_for(0, 1'h0);
      `CHK(mask_flag_out, mb)
    end
    // Disabled source must stay pending, not taken
    @(posedge ref_clk_in);
    irq_enable_in <= 8'h00;
    irq_in <= 8'h02;
    repeat (20) @(negedge ref_clk_in);
    `CHK(busy_out, 1'h0)
    // Enabling it later lets the still latched request through
    @(posedge ref_clk_in);
    irq_enable_in <= 8'hff;
    irq_in <= 8'h00;
    @(negedge ref_clk_in);
    wait_for(0, 1'h1);
    `CHK(vector_sel_out, 4'h3)
    @(posedge ref_clk_in);
    rst_in <= 1'h1;
    @(negedge ref_clk_in);
    `CHK({vector_sel_out, internal_address_bus_out, mask_flag_out}, {4'h0, 16'hfffe, 1'h1})
    `CHK(condition_code_register_out, 8'hff)
    close_out;
  end
endmodule
bind exception_interrupt_sequencer exc_seq_chk u_exc_seq_chk (.ref_clk_in, .rst_in,
  .instr_done_in, .software_trap_instruction_in, .return_from_interrupt_in, .break_in,
  .busy_out, .write_out, .mask_flag_out, .restore_valid_out, .vector_sel_out,
  .internal_address_bus_out);
